/* common/cmsu_consts.vh */
// Register map, field positions, reset values and timing counts of the clock mode switch unit.
`ifndef CMSU_CONSTS_VH
`define CMSU_CONSTS_VH
`define CMSU_OFF_SRC 4'h0
`define CMSU_OFF_OSC 4'h4
`define CMSU_OFF_STAT 4'h8
`define CMSU_OFF_LOOP 4'hc
`define CMSU_SRC_RST 8'h04
`define CMSU_OSC_RST 8'h40
`define CMSU_LOOP_RST 8'h00
`define CMSU_SYS_CLOCK_SELECT_HI 7
`define CMSU_SYS_CLOCK_SELECT_LO 6
`define CMSU_REFERENCE_DIVIDER_HI 5
`define CMSU_REFERENCE_DIVIDER_LO 3
`define CMSU_INTERNAL_REF_SELECT_BIT 2
`define CMSU_BUS_DIVIDER_HI 7
`define CMSU_BUS_DIVIDER_LO 6
`define CMSU_RANGE_BIT 5
`define CMSU_HGO_BIT 4
`define CMSU_LP_BIT 3
`define CMSU_EXT_REF_CRYSTAL_SELECT_BIT 2
`define CMSU_EXT_REF_CLOCK_ENABLE_BIT 1
`define CMSU_LOOP_SELECT_BIT 6
`define CMSU_PLL_MULTIPLIER_HI 3
`define CMSU_PLL_MULTIPLIER_LO 0
`define CMSU_ST_LOCK 6
`define CMSU_ST_LOOP_SELECT_STATUS 5
`define CMSU_ST_IREFST 4
`define CMSU_ST_CLOCK_SOURCE_STATUS_HI 3
`define CMSU_ST_CLOCK_SOURCE_STATUS_LO 2
`define CMSU_ST_OSCILLATOR_READY 1
`define CMSU_CLK_FLL 2'h0
`define CMSU_CLK_INT 2'h1
`define CMSU_CLK_EXT 2'h2
`define CMSU_CLK_PLL 2'h3
`define CMSU_SWITCH_CYC 8'h08
`define CMSU_OSC_START_CYC 8'h40
`define CMSU_LOCK_CYC 8'h20
`endif

/* hw/cmsu_top.v */
// Clock mode switch unit: AXI4-Lite registers, mode tracking and settling status.
`timescale 1ns/1ps
`include "cmsu_consts.vh"

// Functional notes
// - sys_clock_select chooses external, internal or loop
// - reference_divider divides reference by two to the code
// - internal_ref_select picks loop reference source
// - Status bit 4 shows reference in use
// - Status bits 3:2 show active output clock
// - Status bit 1 sets when crystal started
// - Status bit 5 shows PLL feeds loop
// - Status bit 6 shows selected loop locked
// - loop_select bit 6 chooses PLL over FLL
// - pll_multiplier field sets PLL multiply factor
// - Multiplier ignored while FLL selected
// - bus_divider divides output clock
// - Range bit selects high frequency oscillator
// - High gain bit selects high gain oscillator
// - Crystal select bit requests crystal oscillator
// - External clock enable keeps reference running
// - Low power bit bypass gives low-power mode
// - Low-power bypass with the external reference disables both loops
// - FBE keeps FLL running; FBI keeps the selected loop running
// - Bus clock is output clock over two
// - Reset gives FLL engaged internal, divide by two
module cmsu_top (
    input wire aclk,
    input wire aresetn,
    input wire [3:0] s_axi_awaddr,
    input wire [2:0] s_axi_awprot,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [3:0] s_axi_araddr,
    input wire [2:0] s_axi_arprot,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    output reg [1:0] out_clock_select_q,
    output reg [7:0] ref_divide_q,
    output reg [4:0] loop_multiply_q,
    output reg loop_pll_select_q,
    output reg fll_enable_q,
    output reg pll_enable_q,
    output reg [1:0] out_divide_q,
    output reg bus_from_out_div2_q,
    output reg osc_high_range_q,
    output reg osc_high_gain_q,
    output reg osc_crystal_q,
    output reg ext_ref_enable_q,
    output reg [2:0] clock_mode_q
);

    // Mode codes reported on clock_mode_q.
    localparam [2:0] MODE_FEI = 3'h0;
    localparam [2:0] MODE_FEE = 3'h1;
    localparam [2:0] MODE_FBI = 3'h2;
    localparam [2:0] MODE_FBE = 3'h3;
    localparam [2:0] MODE_PEE = 3'h4;
    localparam [2:0] MODE_PBE = 3'h5;
    localparam [2:0] MODE_LOWPOWER_BYPASSED_INTERNAL = 3'h6;
    localparam [2:0] MODE_LOWPOWER_BYPASSED_EXTERNAL = 3'h7;

    reg [7:0] src_ctl_q;
    reg [7:0] osc_ctl_q;
    reg [7:0] loop_ctl_q;
    reg [1:0] clock_source_status_q;
    reg irefst_q;
    reg loop_select_status_q;
    reg lock_q;
    reg oscillator_ready_q;
    reg [7:0] sw_cnt_q;
    reg [7:0] osc_cnt_q;
    reg [7:0] lock_cnt_q;
    reg [3:0] awaddr_q;
    reg aw_have_q;
    reg [31:0] wdata_q;
    reg [3:0] wstrb_q;
    reg w_have_q;

    wire [1:0] sys_clock_select = src_ctl_q[`CMSU_SYS_CLOCK_SELECT_HI:`CMSU_SYS_CLOCK_SELECT_LO];
    wire internal_ref_select = src_ctl_q[`CMSU_INTERNAL_REF_SELECT_BIT];
    wire loop_select = loop_ctl_q[`CMSU_LOOP_SELECT_BIT];
    wire lp = osc_ctl_q[`CMSU_LP_BIT];
    wire ext_ref_crystal_select = osc_ctl_q[`CMSU_EXT_REF_CRYSTAL_SELECT_BIT];
    wire bypass = (sys_clock_select != `CMSU_CLK_FLL);
    wire lp_active = bypass && lp;
    wire [7:0] status = {1'b0, lock_q, loop_select_status_q, irefst_q, clock_source_status_q, oscillator_ready_q, 1'b0};

    // Target output clock code; loop output code depends on the active loop.
    reg [1:0] clk_target;
    always @* begin
        case (sys_clock_select)
            `CMSU_CLK_EXT: clk_target = `CMSU_CLK_EXT;
            `CMSU_CLK_INT: clk_target = `CMSU_CLK_INT;
            default: clk_target = loop_select_status_q ? `CMSU_CLK_PLL : `CMSU_CLK_FLL;
        endcase
    end

    // Both loops stop only in the low-power bypass that runs from the external reference.
    wire loops_on = !(lp_active && !internal_ref_select);

    // With sys_clock_select at the FLL code, a loop may only drive the output once it has locked.
    reg [1:0] clock_source_status_next;
    always @* begin
        if (sys_clock_select == `CMSU_CLK_FLL && !lock_q) begin
            clock_source_status_next = clock_source_status_q;
        end else begin
            clock_source_status_next = clk_target;
        end
    end

    wire clk_moving = (clock_source_status_q != clock_source_status_next);
    wire ref_moving = (irefst_q != internal_ref_select);
    wire loop_moving = (loop_select_status_q != loop_select);
    wire pending = clk_moving || ref_moving || loop_moving;

    // Write and read channel handshakes.
    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire wr_go = aw_have_q && w_have_q && !s_axi_bvalid;
    wire ar_take = s_axi_arvalid && s_axi_arready;

    function [7:0] merge;
        input [7:0] old;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge = strb[0] ? data[7:0] : old;
        end
    endfunction

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= 2'h0;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            awaddr_q <= 4'h0;
            wdata_q <= 32'h0;
            wstrb_q <= 4'h0;
            src_ctl_q <= `CMSU_SRC_RST;
            osc_ctl_q <= `CMSU_OSC_RST;
            loop_ctl_q <= `CMSU_LOOP_RST;
        end else begin
            s_axi_awready <= !aw_have_q && !aw_take;
            s_axi_wready <= !w_have_q && !w_take;
            if (aw_take) begin
                aw_have_q <= 1'b1;
                awaddr_q <= s_axi_awaddr;
            end
            if (w_take) begin
                w_have_q <= 1'b1;
                wdata_q <= s_axi_wdata;
                wstrb_q <= s_axi_wstrb;
            end
            if (wr_go) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= 2'h0;
                if (awaddr_q[1:0] != 2'h0) begin
                    // A misaligned write is refused and leaves every register alone.
                    s_axi_bresp <= 2'h2;
                end else begin
                    // Writes preset fields in any mode, low-power included.
                    case (awaddr_q[3:2])
                        2'h0: begin
                            src_ctl_q <= merge(src_ctl_q, wdata_q, wstrb_q);
                        end
                        2'h1: begin
                            osc_ctl_q <= merge(osc_ctl_q, wdata_q, wstrb_q);
                        end
                        2'h3: begin
                            loop_ctl_q <= merge(loop_ctl_q, wdata_q, wstrb_q);
                        end
                        default: begin
                            // The status word is read-only; a write to it is ignored.
                            s_axi_bresp <= 2'h0;
                        end
                    endcase
                end
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= 2'h0;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !ar_take;
            if (ar_take) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp <= (s_axi_araddr[1:0] != 2'h0) ? 2'h2 : 2'h0;
                case (s_axi_araddr[3:2])
                    2'h0: s_axi_rdata <= {24'h0, src_ctl_q};
                    2'h1: s_axi_rdata <= {24'h0, osc_ctl_q};
                    2'h2: s_axi_rdata <= {24'h0, status};
                    default: s_axi_rdata <= {24'h0, loop_ctl_q};
                endcase
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // Status settling: a switch completes only after a fixed settle time.
    always @(posedge aclk) begin
        if (!aresetn) begin
            clock_source_status_q <= `CMSU_CLK_FLL;
            irefst_q <= 1'b1;
            loop_select_status_q <= 1'b0;
            sw_cnt_q <= 8'h00;
        end else if (!pending) begin
            sw_cnt_q <= 8'h00;
        end else if (sw_cnt_q != `CMSU_SWITCH_CYC) begin
            sw_cnt_q <= sw_cnt_q + 8'h01;
        end else begin
            sw_cnt_q <= 8'h00;
            irefst_q <= internal_ref_select;
            loop_select_status_q <= loop_select;
            clock_source_status_q <= clock_source_status_next;
        end
    end

    // The crystal only starts while it is selected and its reference is wanted.
    wire osc_wanted = ext_ref_crystal_select && (osc_ctl_q[`CMSU_EXT_REF_CLOCK_ENABLE_BIT] || !internal_ref_select);

    // Crystal start-up counter.
    always @(posedge aclk) begin
        if (!aresetn) begin
            osc_cnt_q <= 8'h00;
            oscillator_ready_q <= 1'b0;
        end else if (!osc_wanted) begin
            osc_cnt_q <= 8'h00;
            oscillator_ready_q <= 1'b0;
        end else if (osc_cnt_q != `CMSU_OSC_START_CYC) begin
            osc_cnt_q <= osc_cnt_q + 8'h01;
        end else begin
            oscillator_ready_q <= 1'b1;
        end
    end

    // Lock model: restarts whenever the loop, its reference, the reference divider or, with the PLL selected, multiplier bits 2:0 change.
    reg [7:0] lock_cfg_q;
    wire [7:0] lock_cfg = {internal_ref_select, loop_select, src_ctl_q[`CMSU_REFERENCE_DIVIDER_HI:`CMSU_REFERENCE_DIVIDER_LO],
        loop_select ? loop_ctl_q[`CMSU_PLL_MULTIPLIER_LO+2:`CMSU_PLL_MULTIPLIER_LO] : 3'h0};
    always @(posedge aclk) begin
        if (!aresetn) begin
            lock_cnt_q <= 8'h00;
            lock_q <= 1'b0;
            lock_cfg_q <= 8'h00;
        end else begin
            lock_cfg_q <= lock_cfg;
            if (!loops_on || lock_cfg != lock_cfg_q || loop_select_status_q != loop_select) begin
                lock_cnt_q <= 8'h00;
                lock_q <= 1'b0;
            end else if (lock_cnt_q != `CMSU_LOCK_CYC) begin
                lock_cnt_q <= lock_cnt_q + 8'h01;
            end else begin
                lock_q <= 1'b1;
            end
        end
    end

    // Clock path controls, all registered.
    always @(posedge aclk) begin
        if (!aresetn) begin
            out_clock_select_q <= `CMSU_CLK_FLL;
            ref_divide_q <= 8'h01;
            loop_multiply_q <= 5'h00;
            loop_pll_select_q <= 1'b0;
            fll_enable_q <= 1'b1;
            pll_enable_q <= 1'b0;
            out_divide_q <= 2'h1;
            bus_from_out_div2_q <= 1'b1;
            osc_high_range_q <= 1'b0;
            osc_high_gain_q <= 1'b0;
            osc_crystal_q <= 1'b0;
            ext_ref_enable_q <= 1'b0;
            clock_mode_q <= MODE_FEI;
        end else begin
            out_clock_select_q <= clock_source_status_q;
            ref_divide_q <= 8'h01 << src_ctl_q[`CMSU_REFERENCE_DIVIDER_HI:`CMSU_REFERENCE_DIVIDER_LO];
            loop_multiply_q <= loop_select ? {loop_ctl_q[3:0] + 4'h4, 1'b0} : 5'h00;
            loop_pll_select_q <= loop_select_status_q;
            fll_enable_q <= loops_on && !loop_select_status_q;
            pll_enable_q <= loops_on && loop_select_status_q;
            out_divide_q <= osc_ctl_q[`CMSU_BUS_DIVIDER_HI:`CMSU_BUS_DIVIDER_LO];
            bus_from_out_div2_q <= 1'b1;
            osc_high_range_q <= osc_ctl_q[`CMSU_RANGE_BIT];
            osc_high_gain_q <= osc_ctl_q[`CMSU_HGO_BIT];
            osc_crystal_q <= ext_ref_crystal_select;
            ext_ref_enable_q <= osc_ctl_q[`CMSU_EXT_REF_CLOCK_ENABLE_BIT] || !internal_ref_select || !loops_on;
            case (clock_source_status_q)
                `CMSU_CLK_EXT: begin
                    if (lp_active) begin
                        clock_mode_q <= MODE_LOWPOWER_BYPASSED_EXTERNAL;
                    end else if (loop_select_status_q) begin
                        clock_mode_q <= MODE_PBE;
                    end else begin
                        clock_mode_q <= MODE_FBE;
                    end
                end
                `CMSU_CLK_INT: begin
                    if (lp_active) begin
                        clock_mode_q <= MODE_LOWPOWER_BYPASSED_INTERNAL;
                    end else begin
                        clock_mode_q <= MODE_FBI;
                    end
                end
                `CMSU_CLK_PLL: begin
                    clock_mode_q <= MODE_PEE;
                end
                default: begin
                    clock_mode_q <= irefst_q ? MODE_FEI : MODE_FEE;
                end
            endcase
        end
    end

endmodule

/* sim/cmsu_sw_model.sv */
// Software-side AXI4-Lite master that issues single register writes and reads.
`timescale 1ns/1ps
module cmsu_sw_model (
    input aclk,
    input s_axi_awready,
    input s_axi_wready,
    input s_axi_bvalid,
    input [1:0] s_axi_bresp,
    input s_axi_arready,
    input s_axi_rvalid,
    input [31:0] s_axi_rdata,
    output logic [3:0] s_axi_awaddr = 4'h0,
    output logic [31:0] s_axi_wdata = 32'h0,
    output logic s_axi_awvalid = 1'b0,
    output logic s_axi_wvalid = 1'b0,
    output logic s_axi_bready = 1'b1,
    output logic [3:0] s_axi_araddr = 4'h0,
    output logic s_axi_arvalid = 1'b0,
    output logic s_axi_rready = 1'b1
);
    task automatic wr(input logic [3:0] a, input logic [31:0] d, output logic [1:0] r);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
        end while (s_axi_awvalid && !s_axi_awready || s_axi_wvalid && !s_axi_wready);
        do @(posedge aclk); while (!s_axi_bvalid);
        r = s_axi_bresp;
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        do @(posedge aclk); while (!s_axi_rvalid);
        d = s_axi_rdata;
    endtask
endmodule

/* sim/cmsu_properties.sv */
// Port-level assertions for the clock mode switch unit.
`timescale 1ns/1ps
module cmsu_properties (
    input aclk,
    input aresetn,
    input s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_bvalid, s_axi_bready,
    input [1:0] out_divide_q,
    input [7:0] ref_divide_q,
    input [2:0] clock_mode_q,
    input fll_enable_q, pll_enable_q, bus_from_out_div2_q
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    property p_reset_mode;
        $rose(aresetn) |-> clock_mode_q == 3'h0 && out_divide_q == 2'h1;
    endproperty
    a_reset_mode: assert property (p_reset_mode) else $error("reset mode wrong");
    property p_bus_half;
        1'b1 |-> bus_from_out_div2_q;
    endproperty
    a_bus_half: assert property (p_bus_half) else $error("bus divide lost");
    property p_lowpower_bypassed_external_off;
        clock_mode_q == 3'h7 |-> !fll_enable_q && !pll_enable_q;
    endproperty
    a_lowpower_bypassed_external_off: assert property (p_lowpower_bypassed_external_off) else $error("loop on in lowpower_bypassed_external");
    property p_fbx_fll;
        clock_mode_q inside {3'h2, 3'h3} |-> fll_enable_q;
    endproperty
    a_fbx_fll: assert property (p_fbx_fll) else $error("fll off in bypass");
    property p_pee_pll;
        clock_mode_q == 3'h4 |-> pll_enable_q;
    endproperty
    a_pee_pll: assert property (p_pee_pll) else $error("pll off in pee");
    property p_div_pow2;
        1'b1 |-> $onehot(ref_divide_q);
    endproperty
    a_div_pow2: assert property (p_div_pow2) else $error("divide not power of two");
    property p_read_answer;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid ##1 !s_axi_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("read answer late");
    property p_write_once;
        s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
    endproperty
    a_write_once: assert property (p_write_once) else $error("write answer repeated");
endmodule

/* sim/test_cmsu_top.sv */
// Testbench for the clock mode switch unit driven by a software register master.
`timescale 1ns/1ps
module test_cmsu_top;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [3:0] s_axi_awaddr, s_axi_araddr;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [1:0] s_axi_bresp, s_axi_rresp, out_clock_select_q, out_divide_q, resp;
    logic [7:0] ref_divide_q, d;
    logic [4:0] loop_multiply_q;
    logic loop_pll_select_q, fll_enable_q, pll_enable_q, bus_from_out_div2_q;
    logic osc_high_range_q, osc_high_gain_q, osc_crystal_q, ext_ref_enable_q;
    logic [2:0] clock_mode_q;
    int mismatches = 0, num_checks = 0, cyc = 0;
    cmsu_top dut_u (.*);
    cmsu_sw_model sw_u (.*);
    always #4 aclk = ~aclk;

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    task automatic rchk(input string n, input logic [3:0] a, input logic [31:0] e);
        sw_u.rd(a, rv);
        chk(n, e, rv);
    endtask

    // Reads status until the masked bits match, giving up after a bounded number of reads.
    task automatic poll(input logic [7:0] m, input logic [7:0] v);
        int i;
        rv = {24'h0, ~v};
        for (i = 0; i < 200 && (rv[7:0] & m) !== v; i++) sw_u.rd(4'h8, rv);
        chk("status", {24'h0, v}, {24'h0, rv[7:0] & m});
    endtask

    always @(posedge aclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            mismatches++;
            end_of_test;
        end
    end

    initial begin
        void'($urandom(7757));
        repeat (6) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        rchk("src reset", 4'h0, 32'h04);
        chk("rresp", 32'h0, {30'h0, s_axi_rresp});
        rchk("osc reset", 4'h4, 32'h40);
        rchk("loop reset", 4'hc, 32'h00);
        poll(8'h3f, 8'h10);
        repeat (4) begin
            d = 8'($urandom) & 8'hbf;
            sw_u.wr(4'hc, {24'h0, d}, resp);
            rchk("loop readback", 4'hc, {24'h0, d});
            chk("fll multiplier", 32'h0, {27'h0, loop_multiply_q});
        end
        sw_u.wr(4'h2, 32'h0, resp);
        chk("unaligned", 32'h2, {30'h0, resp});
        rchk("src kept", 4'h0, 32'h04);
        sw_u.wr(4'h4, 32'h36, resp);
        poll(8'h02, 8'h02);
        chk("osc", 32'h0f, {26'h0, out_divide_q, osc_high_range_q, osc_high_gain_q, osc_crystal_q, ext_ref_enable_q});
        sw_u.wr(4'h0, 32'hb8, resp);
        poll(8'h1c, 8'h08);
        chk("divide", 32'd128, {24'h0, ref_divide_q});
        poll(8'h40, 8'h40);
        chk("fbe", 32'h3, {29'h0, clock_mode_q});
        sw_u.wr(4'h4, 32'h3e, resp);
        rchk("osc readback", 4'h4, 32'h3e);
        chk("lowpower_bypassed_external", 32'h1c, {27'h0, clock_mode_q, fll_enable_q, pll_enable_q});
        sw_u.wr(4'h0, 32'h90, resp);
        sw_u.wr(4'hc, 32'h44, resp);
        chk("preset divide", 32'd4, {24'h0, ref_divide_q});
        sw_u.wr(4'h4, 32'h36, resp);
        poll(8'h60, 8'h60);
        chk("multiplier", 32'd16, {27'h0, loop_multiply_q});
        chk("pll active", 32'h1, {31'h0, loop_pll_select_q});
        sw_u.wr(4'h0, 32'h10, resp);
        poll(8'h0c, 8'h0c);
        chk("pee", 32'h4, {29'h0, clock_mode_q});
        chk("out clock", 32'h3, {30'h0, out_clock_select_q});
        end_of_test;
    end
endmodule

bind cmsu_top cmsu_properties chk_u (.*);
